// ==== hdl/spcmi_pkg.sv ====
// constants, field positions and types of the integrity and data-pin block
package spcmi_pkg;
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int CRC_ALERT_NS    = 40;
  localparam int CRC_ALERT_CYC   = (CRC_ALERT_NS * 1000) / CLK_PERIOD_PS;
  localparam int PAR_RECOVER_NS  = 2000;
  localparam int PAR_RECOVER_CYC = (PAR_RECOVER_NS * 1000) / CLK_PERIOD_PS;
  localparam int BURST_BEATS     = 8;
  localparam int CRC_BEATS       = 2;
  localparam int READ_BEAT_CYC   = 2;
  localparam int MR_W            = 18;
  localparam int MR1_TERMINATION_STROBE_BIT    = 11;
  localparam int MR4_VREFMON_BIT = 4;
  localparam int MR5_PARLAT_LSB  = 0;
  localparam int MR5_PARLAT_MSB  = 2;
  localparam int MR5_DM_BIT      = 10;
  localparam int MR5_WDBI_BIT    = 11;
  localparam int MR5_RDBI_BIT    = 12;
  localparam logic [MR_W-1:0] MR1_RESET = 18'h00000;
  localparam logic [MR_W-1:0] MR4_RESET = 18'h00000;
  localparam logic [MR_W-1:0] MR5_RESET = 18'h00000;
  localparam logic [1:0] SEL_MR1 = 2'h1;
  localparam logic [1:0] SEL_MR4 = 2'h2;
  localparam logic [1:0] SEL_MR5 = 2'h3;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'hff;
  localparam int DBI_ZERO_LIMIT = 4;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_DATA = 3'b010,
    WR_CRC  = 3'b100
  } spcmi_wr_t;

  typedef enum logic [2:0] {
    AL_IDLE = 3'b001,
    AL_CRC  = 3'b010,
    AL_PAR  = 3'b100
  } spcmi_alert_t;
endpackage

// ==== hdl/spcmi_top.sv ====
// write buffer and data-integrity top of the memory device
`timescale 1ns/1ps
`default_nettype none

module spcmi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             full;
  logic             empty;

  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
    end else if (inValid && !full) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdPtr <= '0;
    end else if (outReady && !empty) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule

module spcmi_top
  import spcmi_pkg::*;
#(
  parameter bit WIDE16                 = 1'b1,
  parameter logic [17:0] ADDR_USED     = 18'h0ffff,
  parameter int FIFO_DEPTH             = 16,
  parameter int PAR_RECOVER            = spcmi_pkg::PAR_RECOVER_CYC,
  localparam int LANES                 = WIDE16 ? 2 : 1,
  localparam int DQ_W                  = 8 * LANES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  modeWrite,
  input  wire logic [1:0]            modeSelect,
  input  wire logic [spcmi_pkg::MR_W-1:0] modeData,
  input  wire logic                  csN,
  input  wire logic                  activate_input,
  input  wire logic [2:0]            cmdPins,
  input  wire logic [17:0]           addr,
  input  wire logic [1:0]            bank_select_bits,
  input  wire logic [1:0]            bank_group_bits,
  input  wire logic                  ca_parity_input,
  input  wire logic                  wrStart,
  input  wire logic [DQ_W-1:0]       dqIn,
  output logic [DQ_W-1:0]            dqOut,
  output logic [DQ_W-1:0]            dqOe,
  input  wire logic [LANES-1:0]      strobeIn,
  input  wire logic [LANES-1:0]      strobeInN,
  output logic [LANES-1:0]           strobeOut,
  output logic [LANES-1:0]           strobeOutN,
  output logic [LANES-1:0]           strobeOe,
  input  wire logic [LANES-1:0]      maskFlagIn,
  output logic [LANES-1:0]           maskFlagOut,
  output logic [LANES-1:0]           maskFlagOe,
  output logic                       termination_strobe,
  output logic                       vrefMonitor,
  input  wire logic                  alertIn,
  output logic                       alertOut,
  output logic                       alertOe,
  input  wire logic                  connectivity_test_enable,
  output logic                       testActive,
  output logic                       testAlertLevel,
  output logic [DQ_W-1:0]            wrData,
  output logic [LANES-1:0]           wrLaneEn,
  output logic                       wrValid,
  input  wire logic                  wrReady,
  output logic                       wrOverflow,
  input  wire logic [DQ_W-1:0]       rdData,
  input  wire logic                  rdValid,
  output logic                       rdReady,
  output logic                       parityError,
  output logic                       crcError
);
  import spcmi_pkg::*;

  localparam int FW = DQ_W + LANES;

  function automatic logic [7:0] crc8Step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic needInvert(input logic [7:0] b);
    int zeros;
    zeros = 0;
    for (int i = 0; i < 8; i++) begin
      zeros = zeros + (b[i] ? 0 : 1);
    end
    return zeros > DBI_ZERO_LIMIT;
  endfunction

  // mode register copies; reset puts parity latency at zero
  logic [MR_W-1:0] modeRegisterOne;
  logic [MR_W-1:0] modeRegisterFour;
  logic [MR_W-1:0] modeRegisterFive;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      modeRegisterOne  <= MR1_RESET;
      modeRegisterFour <= MR4_RESET;
      modeRegisterFive <= MR5_RESET;
    end else if (modeWrite) begin
      case (modeSelect)
        SEL_MR1: modeRegisterOne  <= modeData;
        SEL_MR4: modeRegisterFour <= modeData;
        SEL_MR5: modeRegisterFive <= modeData;
        default: modeRegisterOne  <= modeRegisterOne;
      endcase
    end
  end

  logic parityOn;
  logic termStrobeOn;
  logic maskOn;
  logic wrInvOn;
  logic rdInvOn;
  assign parityOn     = modeRegisterFive[MR5_PARLAT_MSB:MR5_PARLAT_LSB] != 3'h0;
  // 16-bit parts ignore the termination strobe bit and hold termination_strobe low whatever the controller writes
  assign termStrobeOn = !WIDE16 && modeRegisterOne[MR1_TERMINATION_STROBE_BIT];
  assign maskOn       = !termStrobeOn && modeRegisterFive[MR5_DM_BIT];
  assign wrInvOn      = !termStrobeOn && !modeRegisterFive[MR5_DM_BIT]
                        && modeRegisterFive[MR5_WDBI_BIT];
  assign rdInvOn      = !termStrobeOn && modeRegisterFive[MR5_RDBI_BIT];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      termination_strobe <= 1'b0;
      vrefMonitor        <= 1'b0;
    end else begin
      termination_strobe <= termStrobeOn;
      vrefMonitor        <= modeRegisterFour[MR4_VREFMON_BIT];
    end
  end

  // command parity; csN, cke and termination enable are not inputs of the sum
  logic parityBad;
  assign parityBad = ^{activate_input, cmdPins, addr & ADDR_USED, bank_select_bits,
                       bank_group_bits, ca_parity_input};

  logic parityHit;
  assign parityHit = parityOn && !csN && parityBad;

  // pin synchronisers: strobe pair, data, flag and test pins all pass three flops
  logic [LANES-1:0] sT1, sT2, sT3, sC1, sC2, sC3;
  logic [DQ_W-1:0]  d1, d2, d3;
  logic [LANES-1:0] m1, m2, m3;
  logic [2:0]       tenS;
  logic [2:0]       alS;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {sT1, sT2, sT3} <= '0;
      {sC1, sC2, sC3} <= '1;
      {d1, d2, d3}    <= '0;
      {m1, m2, m3}    <= '1;
      tenS            <= '0;
      alS             <= '1;
    end else begin
      sT1  <= strobeIn;
      sT2  <= sT1;
      sT3  <= sT2;
      sC1  <= strobeInN;
      sC2  <= sC1;
      sC3  <= sC2;
      d1   <= dqIn;
      d2   <= d1;
      d3   <= d2;
      m1   <= maskFlagIn;
      m2   <= m1;
      m3   <= m2;
      tenS <= {tenS[1:0], connectivity_test_enable};
      alS  <= {alS[1:0], alertIn};
    end
  end

  logic testOn;
  assign testOn = tenS[1] && tenS[2];

  // lane strobe level counts only when differential and stable over two stages
  logic [LANES-1:0] strobeLvl;
  logic [LANES-1:0] laneEdge;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strobeLvl <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (laneEdge[l]) begin
          strobeLvl[l] <= sT3[l];
        end
      end
    end
  end

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      laneEdge[l] = (sT2[l] == sT3[l]) && (sC2[l] == sC3[l]) && (sT3[l] != sC3[l])
                    && (sT3[l] != strobeLvl[l]);
    end
  end

  // lane 0 times the beat; the other lane's own strobe qualifies its byte below
  logic beatEdge;
  assign beatEdge = laneEdge[0];

  spcmi_wr_t        wrState;
  logic [3:0]       beatCnt;
  logic [7:0]       crcAcc [LANES];
  logic [DQ_W-1:0]  laneData;
  logic [LANES-1:0] laneKeep;
  logic [DQ_W-1:0]  laneSample;

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      laneSample[8*l +: 8] = d3[8*l +: 8];
      laneData[8*l +: 8]   = (wrInvOn && !m3[l]) ? ~d3[8*l +: 8] : d3[8*l +: 8];
      laneKeep[l]          = laneEdge[l] && !(maskOn && !m3[l]);
    end
  end

  logic crcEnable;
  assign crcEnable = modeRegisterFive[MR5_DM_BIT - 1];

  logic crcMismatch;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrState     <= WR_IDLE;
      beatCnt     <= '0;
      crcMismatch <= 1'b0;
      for (int l = 0; l < LANES; l++) begin
        crcAcc[l] <= CRC8_INIT;
      end
    end else begin
      crcMismatch <= 1'b0;
      case (wrState)
        WR_IDLE: begin
          beatCnt <= '0;
          for (int l = 0; l < LANES; l++) begin
            crcAcc[l] <= CRC8_INIT;
          end
          if (wrStart) begin
            wrState <= WR_DATA;
          end
        end
        WR_DATA: begin
          if (beatEdge) begin
            // the crc runs over the bytes as they stood on the pins
            for (int l = 0; l < LANES; l++) begin
              crcAcc[l] <= crc8Step(crcAcc[l], laneSample[8*l +: 8]);
            end
            beatCnt <= beatCnt + 4'h1;
            if (beatCnt == 4'(BURST_BEATS - 1)) begin
              beatCnt <= '0;
              wrState <= crcEnable ? WR_CRC : WR_IDLE;
            end
          end
        end
        WR_CRC: begin
          if (beatEdge) begin
            beatCnt <= beatCnt + 4'h1;
            if (beatCnt == 4'h0) begin
              for (int l = 0; l < LANES; l++) begin
                if (laneSample[8*l +: 8] != crcAcc[l]) begin
                  crcMismatch <= 1'b1;
                end
              end
            end
            if (beatCnt == 4'(CRC_BEATS - 1)) begin
              wrState <= WR_IDLE;
            end
          end
        end
        default: wrState <= WR_IDLE;
      endcase
    end
  end

  // write buffer; a beat that finds it full is lost and flagged, a strobe cannot wait
  logic          fifoInReady;
  logic          fifoPush;
  logic [FW-1:0] fifoOut;
  logic          fifoOutValid;
  assign fifoPush = (wrState == WR_DATA) && beatEdge && (laneKeep != '0);

  spcmi_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inData   ({laneKeep, laneData}),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (wrReady && !wrValid)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrValid  <= 1'b0;
      wrData   <= '0;
      wrLaneEn <= '0;
    end else if (fifoOutValid && wrReady && !wrValid) begin
      wrValid  <= 1'b1;
      wrData   <= fifoOut[DQ_W-1:0];
      wrLaneEn <= fifoOut[FW-1:DQ_W];
    end else begin
      wrValid  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrOverflow <= 1'b0;
    end else if (fifoPush && !fifoInReady) begin
      wrOverflow <= 1'b1;
    end else if (wrStart) begin
      wrOverflow <= 1'b0;
    end
  end

  // read path: data, flag and strobe change on the same edge
  logic [1:0] rdPace;
  logic       rdBusy;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dqOut       <= '0;
      dqOe        <= '0;
      strobeOut   <= '0;
      strobeOutN  <= '1;
      strobeOe    <= '0;
      maskFlagOut <= '1;
      maskFlagOe  <= '0;
      rdPace      <= '0;
      rdBusy      <= 1'b0;
      rdReady     <= 1'b0;
    end else begin
      rdReady <= 1'b0;
      if (rdBusy) begin
        rdPace <= rdPace + 2'h1;
        if (rdPace == 2'(READ_BEAT_CYC - 1)) begin
          rdBusy <= 1'b0;
          rdPace <= '0;
        end
      end else if (rdValid && !rdReady) begin
        rdBusy     <= 1'b1;
        rdReady    <= 1'b1;
        strobeOut  <= ~strobeOut;
        strobeOutN <= strobeOut;
        strobeOe   <= '1;
        for (int l = 0; l < LANES; l++) begin
          if (rdInvOn && needInvert(rdData[8*l +: 8])) begin
            dqOut[8*l +: 8] <= ~rdData[8*l +: 8];
            maskFlagOut[l]  <= 1'b0;
          end else begin
            dqOut[8*l +: 8] <= rdData[8*l +: 8];
            maskFlagOut[l]  <= 1'b1;
          end
        end
        dqOe       <= '1;
        maskFlagOe <= {LANES{rdInvOn}};
      end else begin
        dqOe       <= '0;
        strobeOe   <= '0;
        maskFlagOe <= '0;
      end
    end
  end

  // alert: parity recovery outranks a crc pulse and restarts on a new parity error
  spcmi_alert_t alState;
  logic [$clog2(PAR_RECOVER + 1)-1:0] alCnt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alState <= AL_IDLE;
      alCnt   <= '0;
    end else begin
      if (parityHit) begin
        alState <= AL_PAR;
        alCnt   <= '0;
      end else begin
        case (alState)
          AL_IDLE: begin
            alCnt <= '0;
            if (crcMismatch) begin
              alState <= AL_CRC;
            end
          end
          AL_CRC: begin
            alCnt <= alCnt + 1'b1;
            if (alCnt == ($bits(alCnt))'(CRC_ALERT_CYC - 1)) begin
              alState <= AL_IDLE;
            end
          end
          AL_PAR: begin
            alCnt <= alCnt + 1'b1;
            if (alCnt == ($bits(alCnt))'(PAR_RECOVER - 1)) begin
              alState <= AL_IDLE;
            end
          end
          default: alState <= AL_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alertOut       <= 1'b0;
      alertOe        <= 1'b0;
      testActive     <= 1'b0;
      testAlertLevel <= 1'b1;
      parityError    <= 1'b0;
      crcError       <= 1'b0;
    end else begin
      alertOut       <= 1'b0;
      alertOe        <= !testOn && (alState != AL_IDLE);
      testActive     <= testOn;
      testAlertLevel <= (alS[1] == alS[2]) ? alS[2] : testAlertLevel;
      parityError    <= alState == AL_PAR;
      crcError       <= alState == AL_CRC;
    end
  end
endmodule

`default_nettype wire

// ==== sim/spcmi_props.sv ====
// checker of alert, parity, strobe and inversion behaviour at the block ports
`timescale 1ns/1ps
`default_nettype none
module spcmi_props #(
  parameter logic [17:0] ADDR_USED   = 18'h0ffff,
  parameter int          PAR_RECOVER = 20
) (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        csN,
  input wire logic        activate_input,
  input wire logic [2:0]  cmdPins,
  input wire logic [17:0] addr,
  input wire logic [1:0]  bank_select_bits,
  input wire logic [1:0]  bank_group_bits,
  input wire logic        ca_parity_input,
  input wire logic [15:0] dqOut,
  input wire logic [15:0] dqOe,
  input wire logic [1:0]  strobeOut,
  input wire logic [1:0]  strobeOutN,
  input wire logic [1:0]  strobeOe,
  input wire logic [1:0]  maskFlagOut,
  input wire logic [1:0]  maskFlagOe,
  input wire logic        termination_strobe,
  input wire logic        alertOut,
  input wire logic        alertOe,
  input wire logic        testActive,
  input wire logic        wrValid,
  input wire logic        wrOverflow,
  input wire logic        rdReady,
  input wire logic        parityError,
  input wire logic        crcError
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int  parRun;
  wire goodCmd = !csN && !(^{ca_parity_input, activate_input, cmdPins, addr & ADDR_USED,
                             bank_select_bits, bank_group_bits});
  // counts how long a parity error has stood; a fresh error may stretch it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) parRun <= 0;
    else parRun <= parityError ? parRun + 1 : 0;
  end
  alert_cause_a: assert property (alertOe |-> parityError || crcError)
    else $error("alert driven with no error pending");
  alert_level_a: assert property (!alertOut)
    else $error("alert pin driven high");
  test_alert_a: assert property (testActive |-> !alertOe)
    else $error("alert driven in test mode");
  par_alert_a: assert property (parityError && !testActive |-> alertOe)
    else $error("parity error without alert");
  par_hold_a: assert property ($fell(parityError) |-> parRun >= PAR_RECOVER - 1)
    else $error("parity alert released early");
  crc_pulse_a: assert property ($rose(alertOe) && !parityError |->
    alertOe [*8] ##1 alertOe ##1 alertOe ##1 (!alertOe || parityError))
    else $error("crc alert pulse length wrong");
  cs_mask_a: assert property ($rose(parityError) |-> !$past(csN, 2))
    else $error("parity error from deselected command");
  par_even_a: assert property (goodCmd |-> ##2 !$rose(parityError))
    else $error("even parity command flagged");
  strobe_pair_a: assert property (strobeOe != 2'b00 |-> strobeOutN == ~strobeOut)
    else $error("strobe pair not complementary");
  read_drive_a: assert property (rdReady |-> dqOe == 16'hffff && strobeOe == 2'b11
    && $changed(strobeOut) ##1 !rdReady)
    else $error("read beat drive wrong");
  dbi_lower_a: assert property (maskFlagOe[0] && !maskFlagOut[0] |->
    $countones(dqOut[7:0]) >= 5)
    else $error("lower byte inverted wrongly");
  dbi_upper_a: assert property (maskFlagOe[1] && !maskFlagOut[1] |->
    $countones(dqOut[15:8]) >= 5)
    else $error("upper byte inverted wrongly");
  tstrobe_off_a: assert property (!termination_strobe)
    else $error("termination strobe on wide part");
  wr_pulse_a: assert property (wrValid |=> !wrValid)
    else $error("write beat pulse too long");
  cover property ($rose(crcError));
  cover property ($rose(parityError));
  cover property ($rose(wrOverflow));
  cover property (rdReady && maskFlagOut != 2'b11);
endmodule
bind spcmi_top spcmi_props #(.ADDR_USED(ADDR_USED), .PAR_RECOVER(PAR_RECOVER)) props_i (
  .ref_clk, .resetn, .csN, .activate_input, .cmdPins, .addr, .bank_select_bits,
  .bank_group_bits, .ca_parity_input, .dqOut, .dqOe, .strobeOut, .strobeOutN, .strobeOe,
  .maskFlagOut, .maskFlagOe, .termination_strobe, .alertOut, .alertOe, .testActive,
  .wrValid, .wrOverflow, .rdReady, .parityError, .crcError);
`default_nettype wire

// ==== sim/spcmi_ctrl_model.sv ====
// controller-side model driving write bursts on data, strobe and mask pins
`timescale 1ns/1ps
`default_nettype none
module spcmi_ctrl_model (
  input  wire logic        go,
  input  wire logic        crcOn,
  input  wire logic        badCrc,
  input  wire logic [3:0]  maskBeat,
  output logic      [15:0] dqIn,
  output logic      [1:0]  strobeIn,
  output logic      [1:0]  strobeInN,
  output logic      [1:0]  maskFlagIn,
  output logic             busy
);
  logic [63:0] lo, hi;
  function automatic logic [7:0] crc8(input logic [63:0] b);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 63; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  initial begin
    dqIn = 16'h0000;
    strobeIn = 2'b00;
    strobeInN = 2'b11;
    maskFlagIn = 2'b11;
    busy = 1'b0;
  end
  // strobe stands still between bursts; data is set a quarter period before each edge
  always @(posedge go) begin
    #1;
    busy = 1'b1;
    for (int i = 0; i < 8; i++) begin
      lo[63 - 8 * i -: 8] = 8'h50 + i[7:0];
      hi[63 - 8 * i -: 8] = 8'ha0 + i[7:0];
    end
    for (int i = 0; i < (crcOn ? 10 : 8); i++) begin
      if (i < 8) dqIn = {hi[63 - 8 * i -: 8], lo[63 - 8 * i -: 8]};
      else dqIn = (i == 8) ? {crc8(hi), crc8(lo) ^ {7'h00, badCrc}} : 16'hffff;
      maskFlagIn = (i == maskBeat) ? 2'b10 : 2'b11;
      #40;
      strobeIn = ~strobeIn;
      strobeInN = ~strobeIn;
      #40;
    end
    dqIn = ~dqIn;
    maskFlagIn = ~maskFlagIn;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ==== sim/spcmi_top_tb.sv ====
// self-checking testbench of the integrity and data-pin block
`timescale 1ns/1ps
`default_nettype none
module spcmi_top_tb;
  import spcmi_pkg::*;
  localparam int          PREC  = 20;
  localparam logic [17:0] AUSED = 18'h0ffff;
  logic        ref_clk, resetn, modeWrite, csN, activate_input, ca_parity_input, wrStart;
  logic [1:0]  modeSelect, bank_select_bits, bank_group_bits, strobeIn, strobeInN;
  logic [17:0] modeData, addr;
  logic [2:0]  cmdPins;
  logic [15:0] dqIn, dqOut, dqOe, dqM, wrData, rdData;
  logic [1:0]  strobeOut, strobeOutN, strobeOe, maskFlagIn, maskFlagOut, maskFlagOe, wrLaneEn;
  logic        termination_strobe, vrefMonitor, alertIn, alertOut, alertOe, extAlert;
  logic        connectivity_test_enable, testActive, testAlertLevel, wrValid, wrReady;
  logic        wrOverflow, rdValid, rdReady, parityError, crcError, go, crcOn, badCrc, mBusy;
  logic [3:0]  maskBeat;
  logic [15:0] gotD [16];
  logic [1:0]  gotE [16];
  int          err_count, check_count, n, alertRun;
  // pull-up on alert: low only while someone pulls it
  assign alertIn = !(alertOe || extAlert);
  assign dqIn = dqOe[0] ? dqOut : dqM;
  spcmi_top #(.PAR_RECOVER(PREC)) uut (.ref_clk, .resetn, .modeWrite, .modeSelect, .modeData,
    .csN, .activate_input, .cmdPins, .addr, .bank_select_bits, .bank_group_bits,
    .ca_parity_input, .wrStart, .dqIn, .dqOut, .dqOe, .strobeIn, .strobeInN, .strobeOut,
    .strobeOutN, .strobeOe, .maskFlagIn, .maskFlagOut, .maskFlagOe, .termination_strobe,
    .vrefMonitor, .alertIn, .alertOut, .alertOe, .connectivity_test_enable, .testActive,
    .testAlertLevel, .wrData, .wrLaneEn, .wrValid, .wrReady, .wrOverflow, .rdData, .rdValid,
    .rdReady, .parityError, .crcError);
  spcmi_ctrl_model ctrl (.go, .crcOn, .badCrc, .maskBeat, .dqIn(dqM), .strobeIn, .strobeInN,
    .maskFlagIn, .busy(mBusy));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic timeout;
    err_count++;
    test_done;
  endtask
  task automatic rst;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(4);
  endtask
  task automatic mode(input logic [1:0] s, input logic [17:0] d);
    @(posedge ref_clk);
    modeWrite <= 1'b1;
    modeSelect <= s;
    modeData <= d;
    @(posedge ref_clk);
    modeWrite <= 1'b0;
  endtask
  task automatic cmd(input logic bad, input logic cs, input logic [7:0] p, input logic [17:0] a);
    @(posedge ref_clk);
    csN <= cs;
    addr <= a;
    {activate_input, cmdPins, bank_select_bits, bank_group_bits} <= p;
    ca_parity_input <= ^{p, a & AUSED} ^ bad;
    @(posedge ref_clk);
    csN <= 1'b1;
  endtask
  task automatic burst(input logic c, input logic b, input logic [3:0] mb);
    @(posedge ref_clk);
    {wrStart, crcOn, badCrc, maskBeat, go} <= {1'b1, c, b, mb, 1'b1};
    @(posedge ref_clk);
    {wrStart, go} <= 2'b00;
    n = 0;
    alertRun = 0;
    repeat (260) begin
      @(negedge ref_clk);
      if (alertOe === 1'b1) alertRun++;
      if (wrValid === 1'b1 && n < 16) begin
        gotD[n] = wrData;
        gotE[n] = wrLaneEn;
        n++;
      end
    end
    chk("model idle", 0, mBusy);
  endtask
  task automatic beats(input logic inv, input logic [3:0] mb);
    chk("beat count", 8, n);
    for (int i = 0; i < 8; i++) begin
      chk("lane enable", (i == mb && !inv) ? 2'b10 : 2'b11, gotE[i]);
      chk("upper byte", 8'ha0 + i[7:0], gotD[i][15:8]);
      if (gotE[i][0] === 1'b1)
        chk("lower byte", (i == mb) ? 8'haf - i[7:0] : 8'h50 + i[7:0], gotD[i][7:0]);
    end
  endtask
  task automatic rd(input logic [15:0] d, input logic [15:0] eq, input logic [1:0] ef);
    int k;
    logic [1:0] s;
    s = strobeOut;
    @(posedge ref_clk);
    rdData <= d;
    rdValid <= 1'b1;
    for (k = 0; k < 8 && rdReady !== 1'b1; k++) cyc(1);
    if (k == 8) timeout;
    chk("read data", eq, dqOut);
    chk("read flag", ef, maskFlagOut);
    chk("read oe", 16'hffff, dqOe);
    chk("strobe edge", 2'(~s), strobeOut);
    chk("strobe pair", 2'(~strobeOut), strobeOutN);
    @(posedge ref_clk);
    rdValid <= 1'b0;
    cyc(4);
  endtask
  task automatic t_reset;
    chk("alert idle", 0, alertOe);
    chk("parity idle", 0, parityError);
    chk("data oe", 0, dqOe);
    chk("flag idle", 2'b11, maskFlagOut);
    chk("test alert", 1, testAlertLevel);
    chk("vref off", 0, vrefMonitor);
    mode(SEL_MR4, 18'h00010);
    cyc(2);
    chk("vref on", 1, vrefMonitor);
    mode(SEL_MR1, 18'h00800);
    cyc(2);
    chk("term strobe", 0, termination_strobe);
  endtask
  task automatic t_parity;
    int k;
    cmd(1'b1, 1'b0, 8'h5a, 18'h00001);
    cyc(4);
    chk("parity off", 0, parityError);
    mode(SEL_MR5, 18'h00001);
    cmd(1'b0, 1'b0, 8'ha5, 18'h30001);
    cmd(1'b1, 1'b1, 8'h3c, 18'h00002);
    cyc(4);
    chk("good or masked", 0, parityError);
    cmd(1'b1, 1'b0, 8'hc3, 18'h0a5a5);
    for (k = 0; k < 8 && parityError !== 1'b1; k++) cyc(1);
    if (k == 8) timeout;
    chk("alert wire", 0, alertIn);
    for (k = 0; k < 100 && parityError === 1'b1; k++) cyc(1);
    chk("parity hold", PREC, k);
    chk("alert freed", 1, alertIn);
  endtask
  task automatic t_write;
    mode(SEL_MR5, 18'h00600);
    burst(1'b1, 1'b0, 4'h3);
    beats(1'b0, 4'h3);
    chk("crc good", 0, alertRun);
    mode(SEL_MR5, 18'h00a00);
    burst(1'b1, 1'b0, 4'h5);
    beats(1'b1, 4'h5);
    mode(SEL_MR5, 18'h00200);
    burst(1'b1, 1'b1, 4'hf);
    chk("crc alert", CRC_ALERT_CYC, alertRun);
    chk("crc freed", 0, crcError);
  endtask
  task automatic t_fifo;
    @(posedge ref_clk);
    wrReady <= 1'b0;
    mode(SEL_MR5, 18'h00400);
    repeat (3) burst(1'b0, 1'b0, 4'hf);
    chk("stalled", 0, n);
    chk("overflow", 1, wrOverflow);
    @(posedge ref_clk);
    wrReady <= 1'b1;
    n = 0;
    repeat (80) begin
      @(negedge ref_clk);
      if (wrValid === 1'b1) n++;
    end
    chk("drained", 16, n);
  endtask
  task automatic t_read;
    mode(SEL_MR5, 18'h01000);
    rd(16'h00ff, 16'hffff, 2'b01);
    rd(16'h0f07, 16'h0ff8, 2'b10);
    mode(SEL_MR5, 18'h00000);
    rd(16'h00ff, 16'h00ff, 2'b11);
  endtask
  task automatic t_test;
    @(posedge ref_clk);
    connectivity_test_enable <= 1'b1;
    extAlert <= 1'b1;
    cyc(6);
    chk("test on", 1, testActive);
    chk("alert input", 0, testAlertLevel);
    mode(SEL_MR5, 18'h00001);
    cmd(1'b1, 1'b0, 8'h81, 18'h00100);
    cyc(4);
    chk("alert undriven", 0, alertOe);
    @(posedge ref_clk);
    {connectivity_test_enable, extAlert} <= 2'b00;
    cyc(6);
    chk("test off", 0, testActive);
  endtask
  initial begin
    {resetn, modeWrite, modeSelect, modeData, addr, cmdPins, wrStart, rdData, rdValid} = '0;
    {activate_input, bank_select_bits, bank_group_bits, ca_parity_input} = '0;
    {connectivity_test_enable, extAlert, go, crcOn, badCrc, err_count, check_count} = '0;
    {csN, wrReady, maskBeat} = {1'b1, 1'b1, 4'hf};
    rst;
    t_reset;
    t_parity;
    t_write;
    t_fifo;
    t_read;
    rst;
    t_reset;
    t_test;
    test_done;
  end
endmodule
`default_nettype wire
